// *** logic/att_trigger.sv ***
// Analog threshold trigger with hysteresis and AHB-Lite register slave
//
// Operation
// R1: working level is sample times multiplier plus offset, before comparing
// R2: multiplier is signed hundredths, limited to plus or minus 10.00
// R3: zero offset is a signed integer limited to plus or minus 10000
// R4: set and clear levels are signed integers limited to 20000 magnitude
// R5: a 0 to 10 V input arrives as integer 0 to 1000
// R6: fraction digits 0 to 3 only shown; comparisons use raw integers
// R7: set not below clear: output high when working level exceeds set
// R8: set not below clear: output low when level at or below clear
// R9: set below clear: high only for set <= level < clear
// R10: set and clear levels come from constant or selected block value
// R11: differential variant: clear is set plus signed span, span 20000 max
// R12: negative span gives hysteresis behaviour
// R13: positive span gives window behaviour
// R14: hysteresis band holds previous output; output low after reset
// R15: recompute once per evaluation with wide signed arithmetic
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
module att_trigger
  import att_pkg::*;
#(
  parameter int NBLK = 16
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog input sample and evaluation strobe
  input wire logic eval_strobe,
  input wire logic signed [ATT_SAMPLE_W-1:0] input_level,
  // Actual values of other function blocks
  input wire logic [NBLK-1:0][15:0] block_values,
  // Results
  output logic trigger_out,
  output logic trig_update,
  output logic signed [ATT_WORK_W-1:0] work_level_out,
  output logic [1:0] frac_digits_out
);

  // ----------------------------------------------------------------
  // State and wiring
  // ----------------------------------------------------------------
  att_cfg_t cfg_reg;
  logic [7:0] addr_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [31:0] hrdata_reg;
  logic trigger_reg;
  logic trig_update_reg;
  logic accept;
  logic signed [ATT_WORK_W-1:0] work;
  logic work_valid;
  logic signed [ATT_WORK_W-1:0] set_lvl;
  logic signed [ATT_WORK_W-1:0] clr_lvl;
  logic trigger_next;
  logic [31:0] rdata_next;

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  // Only NONSEQ or SEQ with the bus ready start a transfer
  assign accept = hsel && htrans[1] && hready;

  // Capture address and direction for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
    end
    else if (hready)
    begin
      addr_reg <= accept ? haddr[7:0] : addr_reg;
      wr_pend_reg <= accept && hwrite;
    end
  end

  // Reads take one wait state so that a write just before is visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_pend_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
    end
    else if (rd_pend_reg)
    begin
      rd_pend_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
    end
    else if (accept && !hwrite)
    begin
      rd_pend_reg <= 1'b1;
      hreadyout_reg <= 1'b0;
    end
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hresp_reg <= 1'b0;
    end
    else
    begin
      hresp_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Multiplier, offset, levels and span are saturated to their legal range as they are stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg.diff_mode <= 1'b0;
      cfg_reg.set_from_blk <= 1'b0;
      cfg_reg.clr_from_blk <= 1'b0;
      cfg_reg.mult <= ATT_MULT_RST;
      cfg_reg.offset <= ATT_ZERO16;
      cfg_reg.set_level <= ATT_ZERO16;
      cfg_reg.clear_level <= ATT_ZERO16;
      cfg_reg.span <= ATT_ZERO16;
      cfg_reg.frac_digits <= 2'h0;
      cfg_reg.set_blk <= '0;
      cfg_reg.clr_blk <= '0;
    end
    else if (wr_pend_reg)
    begin
      unique case (addr_reg)
        ATT_OFS_CTRL:
        begin
          cfg_reg.diff_mode <= hwdata[ATT_CTRL_DIFF_BIT];
          cfg_reg.set_from_blk <= hwdata[ATT_CTRL_SETSRC_BIT];
          cfg_reg.clr_from_blk <= hwdata[ATT_CTRL_CLRSRC_BIT];
        end
        ATT_OFS_MULT:
        begin
          cfg_reg.mult <= att_sat(hwdata, ATT_MULT_MAX); // see R2
        end
        ATT_OFS_OFFSET:
        begin
          cfg_reg.offset <= att_sat(hwdata, ATT_OFFS_MAX); // see R3
        end
        ATT_OFS_SET:
        begin
          cfg_reg.set_level <= att_sat(hwdata, ATT_LEVEL_MAX); // see R4
        end
        ATT_OFS_CLEAR:
        begin
          cfg_reg.clear_level <= att_sat(hwdata, ATT_LEVEL_MAX); // see R4
        end
        ATT_OFS_SPAN:
        begin
          cfg_reg.span <= att_sat(hwdata, ATT_SPAN_MAX); // see R11
        end
        ATT_OFS_FRAC:
        begin
          cfg_reg.frac_digits <= hwdata[1:0] & ATT_FRAC_MAX; // see R6
        end
        ATT_OFS_BLKSEL:
        begin
          cfg_reg.set_blk <= hwdata[ATT_BLKSEL_SET_LSB +: ATT_BLK_W];
          cfg_reg.clr_blk <= hwdata[ATT_BLKSEL_CLR_LSB +: ATT_BLK_W];
        end
        default:
        begin
          cfg_reg <= cfg_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Signed fields read back sign-extended; unmapped offsets read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    unique case (addr_reg)
      ATT_OFS_CTRL:
      begin
        rdata_next[ATT_CTRL_DIFF_BIT] = cfg_reg.diff_mode;
        rdata_next[ATT_CTRL_SETSRC_BIT] = cfg_reg.set_from_blk;
        rdata_next[ATT_CTRL_CLRSRC_BIT] = cfg_reg.clr_from_blk;
      end
      ATT_OFS_MULT: rdata_next = 32'(cfg_reg.mult);
      ATT_OFS_OFFSET: rdata_next = 32'(cfg_reg.offset);
      ATT_OFS_SET: rdata_next = 32'(cfg_reg.set_level);
      ATT_OFS_CLEAR: rdata_next = 32'(cfg_reg.clear_level);
      ATT_OFS_SPAN: rdata_next = 32'(cfg_reg.span);
      ATT_OFS_FRAC: rdata_next[1:0] = cfg_reg.frac_digits;
      ATT_OFS_BLKSEL:
      begin
        rdata_next[ATT_BLKSEL_SET_LSB +: ATT_BLK_W] = cfg_reg.set_blk;
        rdata_next[ATT_BLKSEL_CLR_LSB +: ATT_BLK_W] = cfg_reg.clr_blk;
      end
      ATT_OFS_STATUS: rdata_next[0] = trigger_reg;
      ATT_OFS_WORK: rdata_next = 32'(work);
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data loaded during the wait state, held until the next read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_reg <= 32'h0000_0000;
    end
    else if (rd_pend_reg)
    begin
      hrdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Scaling stage
  // ----------------------------------------------------------------
  // Sample range 0 to 1000 for a full-scale voltage input fits easily
  att_scale u_scale (
    .hclk(hclk),
    .hresetn(hresetn),
    .eval_strobe(eval_strobe),
    .sample(input_level), // see R5
    .mult(cfg_reg.mult),
    .offset(cfg_reg.offset),
    .work_reg(work),
    .work_valid_reg(work_valid)
  );

  // ----------------------------------------------------------------
  // Level selection
  // ----------------------------------------------------------------
  // Out-of-range block numbers yield zero rather than an undefined index
  function automatic logic signed [ATT_WORK_W-1:0] blk_value(
    input logic [ATT_BLK_W-1:0] idx,
    input logic [NBLK-1:0][15:0] vals
  );
    logic signed [15:0] v;
    v = 16'sh0000;
    if (int'(idx) < NBLK)
    begin
      v = vals[idx];
    end
    return ATT_WORK_W'(v);
  endfunction

  // Set from constant or block; clear from constant, block or set + span
  always_comb
  begin
    set_lvl = cfg_reg.set_from_blk
      ? blk_value(cfg_reg.set_blk, block_values) // see R10
      : ATT_WORK_W'(cfg_reg.set_level);
    if (cfg_reg.diff_mode)
    begin
      clr_lvl = set_lvl + ATT_WORK_W'(cfg_reg.span); // see R11
    end
    else if (cfg_reg.clr_from_blk)
    begin
      clr_lvl = blk_value(cfg_reg.clr_blk, block_values); // see R10
    end
    else
    begin
      clr_lvl = ATT_WORK_W'(cfg_reg.clear_level);
    end
  end

  // ----------------------------------------------------------------
  // Threshold comparison
  // ----------------------------------------------------------------
  // Raw integers only; the decimal point setting never enters here
  always_comb
  begin
    trigger_next = trigger_reg; // see R14
    if (set_lvl >= clr_lvl) // see R12
    begin
      if (work > set_lvl)
      begin
        trigger_next = 1'b1; // see R7
      end
      else if (work <= clr_lvl)
      begin
        trigger_next = 1'b0; // see R8
      end
    end
    else
    begin
      trigger_next = (work >= set_lvl) && (work < clr_lvl); // see R9, R13
    end
  end

  // Output updates only when a fresh working level arrives
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trigger_reg <= 1'b0; // see R14
    end
    else if (work_valid)
    begin
      trigger_reg <= trigger_next; // see R15, see R6
    end
  end

  // Pulse marking each evaluated result
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trig_update_reg <= 1'b0;
    end
    else
    begin
      trig_update_reg <= work_valid;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Presentation only: fraction digits go out for the display side
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      work_level_out <= '0;
      frac_digits_out <= 2'h0;
    end
    else
    begin
      work_level_out <= work;
      frac_digits_out <= cfg_reg.frac_digits; // see R6
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign trigger_out = trigger_reg;
  assign trig_update = trig_update_reg;

endmodule

// *** logic/att_pkg.sv ***
// Package: register map, limits and types of the analog threshold trigger
package att_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ATT_OFS_CTRL = 8'h00;
  localparam logic [7:0] ATT_OFS_MULT = 8'h04;
  localparam logic [7:0] ATT_OFS_OFFSET = 8'h08;
  localparam logic [7:0] ATT_OFS_SET = 8'h0c;
  localparam logic [7:0] ATT_OFS_CLEAR = 8'h10;
  localparam logic [7:0] ATT_OFS_SPAN = 8'h14;
  localparam logic [7:0] ATT_OFS_FRAC = 8'h18;
  localparam logic [7:0] ATT_OFS_BLKSEL = 8'h1c;
  localparam logic [7:0] ATT_OFS_STATUS = 8'h20;
  localparam logic [7:0] ATT_OFS_WORK = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ATT_CTRL_DIFF_BIT = 0;
  localparam int ATT_CTRL_SETSRC_BIT = 1;
  localparam int ATT_CTRL_CLRSRC_BIT = 2;
  localparam int ATT_BLKSEL_SET_LSB = 0;
  localparam int ATT_BLKSEL_CLR_LSB = 8;
  localparam int ATT_BLK_W = 8;

  // ----------------------------------------------------------------
  // Value limits and scaling
  // ----------------------------------------------------------------
  localparam logic signed [31:0] ATT_MULT_MAX = 32'sd1000;
  localparam logic signed [31:0] ATT_MULT_SCALE = 32'sd100;
  localparam logic signed [31:0] ATT_OFFS_MAX = 32'sd10000;
  localparam logic signed [31:0] ATT_LEVEL_MAX = 32'sd20000;
  localparam logic signed [31:0] ATT_SPAN_MAX = 32'sd20000;
  localparam logic [1:0] ATT_FRAC_MAX = 2'h3;
  localparam int ATT_VOLT_FULL = 1000;
  localparam int ATT_SAMPLE_W = 16;
  localparam int ATT_WORK_W = 24;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic signed [15:0] ATT_MULT_RST = 16'sh0064;
  localparam logic signed [15:0] ATT_ZERO16 = 16'sh0000;

  // Configuration carrier
  typedef struct packed {
    logic diff_mode;
    logic set_from_blk;
    logic clr_from_blk;
    logic signed [15:0] mult;
    logic signed [15:0] offset;
    logic signed [15:0] set_level;
    logic signed [15:0] clear_level;
    logic signed [15:0] span;
    logic [1:0] frac_digits;
    logic [ATT_BLK_W-1:0] set_blk;
    logic [ATT_BLK_W-1:0] clr_blk;
  } att_cfg_t;

  // Saturate a written word to plus or minus lim
  function automatic logic signed [15:0] att_sat(
    input logic signed [31:0] v,
    input logic signed [31:0] lim
  );
    logic signed [31:0] r;
    r = v;
    if (v > lim)
    begin
      r = lim;
    end
    else if (v < -lim)
    begin
      r = -lim;
    end
    return r[15:0];
  endfunction

endpackage

// *** logic/att_scale.sv ***
// Scaling stage: sample times multiplier plus zero offset, registered
module att_scale
  import att_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Sample in
  input wire logic eval_strobe,
  input wire logic signed [ATT_SAMPLE_W-1:0] sample,
  // Scaling parameters
  input wire logic signed [15:0] mult,
  input wire logic signed [15:0] offset,
  // Working level out
  output logic signed [ATT_WORK_W-1:0] work_reg,
  output logic work_valid_reg
);

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // 32 bits hold 32767 * 1000 with room; no overflow possible
  logic signed [31:0] prod;
  logic signed [31:0] quot;
  logic signed [31:0] sum;

  // Multiplier is in hundredths, so divide back; truncates toward zero
  always_comb
  begin
    prod = 32'(sample) * 32'(mult); // see R1, see R15
    quot = prod / ATT_MULT_SCALE; // see R2
    sum = quot + 32'(offset); // see R1
  end

  // ----------------------------------------------------------------
  // Output register, one result per evaluation cycle
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      work_reg <= '0;
    end
    else if (eval_strobe)
    begin
      work_reg <= sum[ATT_WORK_W-1:0]; // see R15
    end
  end

  // Valid pulse one cycle after the strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      work_valid_reg <= 1'b0;
    end
    else
    begin
      work_valid_reg <= eval_strobe;
    end
  end

endmodule

// *** tb/att_trigger_sva.sv ***
// Checker: latency and handshake properties of the trigger
module att_trigger_sva
  import att_pkg::*;
#(
  parameter int NBLK = 16
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Evaluation
  input wire logic eval_strobe,
  input wire logic trigger_out,
  input wire logic trig_update,
  input wire logic signed [ATT_WORK_W-1:0] work_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic take;
  // Request accepted at this edge
  assign take = hsel && htrans[1] && hready;
  AST_UPD_LAT:
    assert property (eval_strobe |-> ##2 trig_update)
    else $error("no update two cycles after strobe");
  AST_UPD_SRC:
    assert property (trig_update |-> $past(eval_strobe, 2))
    else $error("update without a strobe");
  AST_Q_HOLD:
    assert property ($changed(trigger_out) |-> trig_update)
    else $error("trigger moved between evaluations");
  AST_Q_RST:
    assert property ($rose(hresetn) |-> !trigger_out && !trig_update)
    else $error("trigger not low after reset");
  AST_WORK_SYNC:
    assert property ($changed(work_level_out) |-> trig_update)
    else $error("working level moved without update");
  // Bus handshake as agreed in the hand-over
  AST_RD_WAIT:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WR_NOWAIT:
    assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_OKAY:
    assert property (!hresp)
    else $error("error response");
  // Main scenarios reached
  cover property (trig_update && trigger_out);
  cover property ($fell(trigger_out));
  cover property (take && !hwrite);
endmodule

bind att_trigger att_trigger_sva #(.NBLK(NBLK)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .eval_strobe(eval_strobe), .trigger_out(trigger_out),
  .trig_update(trig_update), .work_level_out(work_level_out)
);

// *** tb/att_src_model.sv ***
// Partner model: analog channel and neighbouring block values
module att_src_model
  import att_pkg::*;
#(
  parameter int NBLK = 16
)
(
  // Clock
  input wire logic hclk,
  // Sample out
  output logic eval_strobe,
  output logic signed [ATT_SAMPLE_W-1:0] input_level,
  // Actual values of other blocks
  output logic [NBLK-1:0][15:0] block_values
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle lines start on a pattern, never a fake sample
  initial
  begin
    eval_strobe = 1'b0;
    input_level = 16'sh5a5a;
    block_values = '0;
  end
  // One sample; the line is inverted once it has been taken
  task automatic sample(input int v);
    @(posedge hclk);
    eval_strobe <= 1'b1;
    input_level <= 16'(v);
    @(posedge hclk);
    eval_strobe <= 1'b0;
    input_level <= ~16'(v);
  endtask
  // Actual value of a block, by block number
  task automatic blk(input int n, input int v);
    block_values[n] <= 16'(v);
  endtask
endmodule

// *** tb/att_trigger_tb_top.sv ***
// Testbench: registers, scaling and threshold output of the trigger
module att_trigger_tb_top import att_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic eval_strobe;
  logic signed [15:0] input_level;
  logic [15:0][15:0] block_values;
  logic trigger_out;
  logic trig_update;
  logic signed [23:0] work_level_out;
  logic [1:0] frac_digits_out;
  logic [31:0] d;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 32'hadfe6830;
  int st = 0;
  int cl = 0;
  int q = 0;
  int mu = 100;
  int of = 0;
  int lw = 0;
  logic [7:0] ao[8] = '{ATT_OFS_MULT, ATT_OFS_MULT, ATT_OFS_OFFSET,
    ATT_OFS_SET, ATT_OFS_CLEAR, ATT_OFS_SPAN, ATT_OFS_FRAC, 8'h40};
  int wv[8] = '{-2000, 999, -20000, 30000, -25000, 20001, 7, 5};
  int ex[8] = '{-1000, 999, -10000, 20000, -20000, 20000, 3, 0};
  int smp[12] = '{600, 500, 301, 300, 201, 200, 499, 400, 399, 199, 1000, 0};
  int cc[4] = '{0, 0, 1, 1};
  int cs[4] = '{500, 200, 300, 300};
  int ck[4] = '{200, 500, -100, 100};

  // ----------------
  // Clock and parts
  // ----------------
  always #5 hclk = ~hclk;
  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  att_trigger DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .eval_strobe(eval_strobe),
    .input_level(input_level), .block_values(block_values),
    .trigger_out(trigger_out), .trig_update(trig_update),
    .work_level_out(work_level_out), .frac_digits_out(frac_digits_out)
  );
  att_src_model src (
    .hclk(hclk), .eval_strobe(eval_strobe), .input_level(input_level),
    .block_values(block_values)
  );

  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: %h, expected %h", $time, s, e);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Address phase held until taken, then data phase until ready
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    d = hrdata;
  endtask
  // Levels kept in integers; clear is derived in the differential case
  task automatic cfg(input int c, m, o, s, k);
    mu = m;
    of = o;
    st = s;
    cl = c[0] ? s + k : k;
    bus(1'b1, ATT_OFS_CTRL, c);
    bus(1'b1, ATT_OFS_MULT, m);
    bus(1'b1, ATT_OFS_OFFSET, o);
    bus(1'b1, ATT_OFS_SET, s);
    bus(1'b1, ATT_OFS_CLEAR, k);
    bus(1'b1, ATT_OFS_SPAN, k);
  endtask
  // Model of the output: hold inside a hysteresis band
  function automatic int nq(int w, int s, int c, int p);
    if (s >= c)
      return w > s ? 1 : (w <= c ? 0 : p);
    return int'(w >= s && w < c);
  endfunction
  task automatic ev(input int v);
    int w;
    w = v * mu / 100 + of;
    q = nq(w, st, cl, q);
    src.sample(v);
    repeat (8)
    begin
      @(posedge hclk);
      #1;
      if (trig_update === 1'b1)
        break;
    end
    lw = w;
    chk(32'(trig_update), 1);
    chk(32'(work_level_out), w);
    chk(32'(trigger_out), q);
  endtask

  // ----------------
  // Sequence
  // ----------------
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      num_errors++;
      results();
    end
  end
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(trigger_out), 0);
    bus(1'b0, ATT_OFS_MULT, 0);
    chk(d, 32'(ATT_MULT_RST));
    // Out-of-range writes land on the limits; the unmapped offset reads zero
    foreach (wv[i])
    begin
      bus(1'b1, ao[i], wv[i]);
      bus(1'b0, ao[i], 0);
      chk(d, ex[i]);
    end
    chk(32'(frac_digits_out), 3);
    // Plain and differential boundaries, fraction digits left at 3
    foreach (cc[n])
    begin
      cfg(cc[n], 100, 0, cs[n], ck[n]);
      foreach (smp[i]) ev(smp[i]);
    end
    // Levels taken from other blocks
    bus(1'b1, ATT_OFS_BLKSEL, 32'h0000_0503);
    bus(1'b0, ATT_OFS_BLKSEL, 0);
    chk(d, 32'h0000_0503);
    cfg(6, 100, 0, 0, 0);
    bus(1'b0, ATT_OFS_CTRL, 0);
    chk(d, 6);
    for (int j = 0; j < 2; j++)
    begin
      src.blk(3, 250 + 200 * j);
      src.blk(5, -50);
      st = 250 + 200 * j;
      cl = -50;
      foreach (smp[i]) ev(smp[i]);
    end
    // Clear block number past the table reads as zero
    bus(1'b1, ATT_OFS_BLKSEL, 32'h0000_1403);
    cl = 0;
    foreach (smp[i]) ev(smp[i]);
    // Random gains, offsets and levels
    repeat (20)
    begin
      cfg({$random(seed)} % 2, $random(seed) % 1001,
        $random(seed) % 10001, $random(seed) % 20001,
        $random(seed) % 20001);
      repeat (10) ev({$random(seed)} % 1001);
    end
    bus(1'b0, ATT_OFS_STATUS, 0);
    chk(32'(d[0]), q);
    bus(1'b0, ATT_OFS_WORK, 0);
    chk(d, lw);
    results();
  end
endmodule
